// ===== design/page_stack_pkg.sv
package page_stack_pkg;

    // ------------------------------------------------------------
    // Address space
    // ------------------------------------------------------------
    localparam logic [7:0] SFR_SPACE_LO      = 8'h80;
    localparam logic [7:0] SFR_SPACE_HI      = 8'hFF;
    localparam logic [2:0] BIT_ADDR_LOW_MASK = 3'h0;

    // ------------------------------------------------------------
    // Pages
    // ------------------------------------------------------------
    localparam logic [7:0] PAGE_MAIN   = 8'h00;
    localparam logic [7:0] PAGE_BUSCTL = 8'h0C;
    localparam logic [7:0] PAGE_CONFIG = 8'h0F;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] PAGE_CONTROL_ADDR      = 8'h84;
    localparam logic [7:0] PAGE_STACK_SECOND_ADDR = 8'h85;
    localparam logic [7:0] PAGE_SELECT_ADDR       = 8'hA7;
    localparam logic [7:0] PAGE_STACK_BOTTOM_ADDR = 8'hA6;

    // ------------------------------------------------------------
    // Fields and reset values
    // ------------------------------------------------------------
    localparam int         AUTO_PAGE_ENABLE_BIT   = 0;
    localparam logic       AUTO_PAGE_ENABLE_RESET = 1'b1;
    localparam logic [7:0] PAGE_RESET             = 8'h00;
    localparam logic [7:0] EMPTY_PAGE             = 8'h00;

    // Stack movement kinds
    typedef enum logic [1:0] {
        MOVE_NONE = 2'b00,
        MOVE_PUSH = 2'b01,
        MOVE_POP  = 2'b10
    } move_type;

endpackage : page_stack_pkg

// ===== design/sfr_access_if.sv
interface sfr_access_if;
    logic [7:0] addr;
    logic       direct;
    logic [7:0] page;
    logic       sfr_space;
    logic       bit_ok;
    logic       all_pages;
    logic       own_hit;
    logic       sel_ctrl;
    logic       sel_page;
    logic       sel_second;
    logic       sel_bottom;

    modport decoder (
        input  addr,
        input  direct,
        input  page,
        output sfr_space,
        output bit_ok,
        output all_pages,
        output own_hit,
        output sel_ctrl,
        output sel_page,
        output sel_second,
        output sel_bottom
    );

    modport core (
        output addr,
        output direct,
        output page,
        input  sfr_space,
        input  bit_ok,
        input  all_pages,
        input  own_hit,
        input  sel_ctrl,
        input  sel_page,
        input  sel_second,
        input  sel_bottom
    );
endinterface : sfr_access_if

// ===== design/sfr_addr_decode.sv
module sfr_addr_decode (
    sfr_access_if.decoder acc
);
    import page_stack_pkg::*;

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    logic in_space;

    assign in_space = acc.direct && (acc.addr >= SFR_SPACE_LO);
    assign acc.sfr_space = in_space;

    assign acc.bit_ok = in_space && (acc.addr[2:0] == BIT_ADDR_LOW_MASK);

    assign acc.sel_page   = in_space && (acc.addr == PAGE_SELECT_ADDR);
    assign acc.sel_second = in_space && (acc.addr == PAGE_STACK_SECOND_ADDR);
    assign acc.sel_bottom = in_space && (acc.addr == PAGE_STACK_BOTTOM_ADDR);
    assign acc.all_pages  = acc.sel_page || acc.sel_second || acc.sel_bottom;

    assign acc.sel_ctrl = in_space && (acc.addr == PAGE_CONTROL_ADDR)
                          && (acc.page == PAGE_CONFIG);

    assign acc.own_hit = acc.all_pages || acc.sel_ctrl;
endmodule : sfr_addr_decode

// ===== design/sfr_page_stack_control.sv
// Contract
// - Direct 0x80-0xFF goes to register space
// - Rows ending 0 or 8 bit-addressable
// - Pages 0x00, 0x0C, 0x0F implemented
// - Three-entry page stack
// - Interrupt entry pushes stack
// - Load source page, bus unit 0x0C
// - Return pops stack
// - Empty bottom pops as 0x00
// - Software writes never push or pop
// - Lower entries writable inside handler
// - Page write changes active page now
// - All-page registers ignore page
// - Nested push overwrites bottom
// - Enable clear freezes auto paging
// - Enable resets to one
// - Control bits 7:1 read zero
// - Control at 0x84 page 0x0F
// - Page select readable, writable everywhere
// - Second entry at 0x85, resets zero
module sfr_page_stack_control (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst_n,
    // Core register access
    input  wire logic [7:0] addr,
    input  wire logic       direct,
    input  wire logic       wr,
    input  wire logic       rd,
    input  wire logic       bit_access,
    input  wire logic [7:0] wdata,
    output logic      [7:0] rdata,
    output logic            rdata_valid,
    // Decode results
    output logic            sfr_space,
    output logic            bit_ok,
    output logic            own_hit,
    output logic      [7:0] page,
    output logic            page_known,
    // Interrupt sequencer
    input  wire logic       irq_enter,
    input  wire logic       irq_from_bus_unit,
    input  wire logic       irq_return
);
    import page_stack_pkg::*;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic [7:0] page_select_q;
    logic [7:0] page_stack_second_q;
    logic [7:0] page_stack_bottom_q;
    logic       bottom_full_q;
    logic       auto_page_enable_q;
    move_type   move;
    logic [7:0] src_page;
    logic       wr_ok;

    sfr_access_if acc ();

    assign acc.addr   = addr;
    assign acc.direct = direct;
    assign acc.page   = page_select_q;

    sfr_addr_decode u_decode (
        .acc (acc)
    );

    assign sfr_space = acc.sfr_space;
    assign bit_ok    = acc.bit_ok;
    assign own_hit   = acc.own_hit;
    assign page      = page_select_q;

    assign page_known = (page_select_q == PAGE_MAIN)
                        || (page_select_q == PAGE_BUSCTL)
                        || (page_select_q == PAGE_CONFIG);

    // Byte writes anywhere; bit writes go only to bit rows
    assign wr_ok = wr && (!bit_access || acc.bit_ok);

    // ------------------------------------------------------------
    // Stack movement
    // ------------------------------------------------------------
    // enable gates movement
    always_comb begin
        move = MOVE_NONE;
        if (auto_page_enable_q && irq_enter) begin
            move = MOVE_PUSH;
        end else if (auto_page_enable_q && irq_return) begin
            move = MOVE_POP;
        end
    end

    assign src_page = irq_from_bus_unit ? PAGE_BUSCTL : PAGE_MAIN;

    // ------------------------------------------------------------
    // Stack registers
    // ------------------------------------------------------------
    // top entry
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            page_select_q <= PAGE_RESET;
        end else begin
            unique case (move)
                MOVE_PUSH: page_select_q <= src_page;
                MOVE_POP:  page_select_q <= page_stack_second_q;
                default: begin
                    if (wr_ok && acc.sel_page) begin
                        page_select_q <= wdata;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            page_stack_second_q <= PAGE_RESET;
        end else begin
            unique case (move)
                MOVE_PUSH: page_stack_second_q <= page_select_q;
                MOVE_POP:  page_stack_second_q <= page_stack_bottom_q;
                default: begin
                    if (wr_ok && acc.sel_second) begin
                        page_stack_second_q <= wdata;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            page_stack_bottom_q <= PAGE_RESET;
            bottom_full_q       <= 1'b0;
        end else begin
            unique case (move)
                MOVE_PUSH: begin
                    page_stack_bottom_q <= page_stack_second_q;
                    bottom_full_q       <= 1'b1;
                end
                MOVE_POP: begin
                    page_stack_bottom_q <= EMPTY_PAGE;
                    bottom_full_q       <= 1'b0;
                end
                default: begin
                    if (wr_ok && acc.sel_bottom) begin
                        page_stack_bottom_q <= wdata;
                        bottom_full_q       <= 1'b1;
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Control register
    // ------------------------------------------------------------
    // enable resets set
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            auto_page_enable_q <= AUTO_PAGE_ENABLE_RESET;
        end else if (wr_ok && acc.sel_ctrl) begin
            auto_page_enable_q <= wdata[AUTO_PAGE_ENABLE_BIT];
        end
    end

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------
    // readback registered
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata       <= 8'h00;
            rdata_valid <= 1'b0;
        end else begin
            rdata_valid <= rd && acc.own_hit;
            if (rd && acc.sel_page) begin
                rdata <= page_select_q;
            end else if (rd && acc.sel_second) begin
                rdata <= page_stack_second_q;
            end else if (rd && acc.sel_bottom) begin
                rdata <= page_stack_bottom_q;
            end else if (rd && acc.sel_ctrl) begin
                rdata <= {7'h00, auto_page_enable_q};
            end else begin
                rdata <= 8'h00;
            end
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    push_page_a: assert property (@(posedge clk) disable iff (!rst_n)
        auto_page_enable_q && irq_enter |=> page_select_q ==
            ($past(irq_from_bus_unit) ? PAGE_BUSCTL : PAGE_MAIN))
        else $error("page not loaded on entry");

    push_shift_a: assert property (@(posedge clk) disable iff (!rst_n)
        auto_page_enable_q && irq_enter |=>
            page_stack_second_q == $past(page_select_q)
            && page_stack_bottom_q == $past(page_stack_second_q))
        else $error("push did not shift stack");

    pop_shift_a: assert property (@(posedge clk) disable iff (!rst_n)
        auto_page_enable_q && !irq_enter && irq_return |=>
            page_select_q == $past(page_stack_second_q)
            && page_stack_second_q == $past(page_stack_bottom_q))
        else $error("pop did not restore");

    pop_empty_a: assert property (@(posedge clk) disable iff (!rst_n)
        auto_page_enable_q && !irq_enter && irq_return
        && !bottom_full_q |=> page_stack_second_q == EMPTY_PAGE)
        else $error("empty pop not zero");

    frozen_stack_a: assert property (@(posedge clk) disable iff (!rst_n)
        !auto_page_enable_q && !wr |=> $stable(page_select_q)
            && $stable(page_stack_second_q))
        else $error("stack moved while disabled");

    page_write_a: assert property (@(posedge clk) disable iff (!rst_n)
        move == MOVE_NONE && wr && !bit_access && acc.sel_page |=>
            page_select_q == $past(wdata)
            && $stable(page_stack_second_q))
        else $error("page write wrong");

    ctrl_read_a: assert property (@(posedge clk) disable iff (!rst_n)
        rd && acc.sel_ctrl |=> rdata[7:1] == 7'h00
            && rdata[0] == $past(auto_page_enable_q))
        else $error("control readback wrong");

    ctrl_decode_a: assert property (@(posedge clk) disable iff (!rst_n)
        acc.sel_ctrl |-> page_select_q == PAGE_CONFIG
            && addr == PAGE_CONTROL_ADDR)
        else $error("control decoded off page");

    space_decode_a: assert property (@(posedge clk) disable iff (!rst_n)
        sfr_space == (direct && addr[7]))
        else $error("register space decode wrong");

    bit_row_a: assert property (@(posedge clk) disable iff (!rst_n)
        bit_ok == (direct && addr[7] && addr[2:0] == BIT_ADDR_LOW_MASK))
        else $error("bit row decode wrong");

    all_page_a: assert property (@(posedge clk) disable iff (!rst_n)
        direct && (addr == PAGE_SELECT_ADDR
            || addr == PAGE_STACK_SECOND_ADDR
            || addr == PAGE_STACK_BOTTOM_ADDR) |-> own_hit)
        else $error("all-page register missed");

    second_write_a: assert property (@(posedge clk) disable iff (!rst_n)
        move == MOVE_NONE && wr && !bit_access && acc.sel_second |=>
            page_stack_second_q == $past(wdata)
            && $stable(page_select_q))
        else $error("second entry write wrong");

    bottom_write_a: assert property (@(posedge clk) disable iff (!rst_n)
        move == MOVE_NONE && wr && !bit_access && acc.sel_bottom |=>
            page_stack_bottom_q == $past(wdata)
            && $stable(page_select_q)
            && $stable(page_stack_second_q))
        else $error("bottom entry write wrong");

    pop_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
        move == MOVE_POP |=> page_stack_bottom_q == EMPTY_PAGE)
        else $error("bottom not emptied by pop");

    irq_frozen_a: assert property (@(posedge clk) disable iff (!rst_n)
        !auto_page_enable_q && (irq_enter || irq_return) && !wr |=>
            $stable(page_select_q) && $stable(page_stack_second_q)
            && $stable(page_stack_bottom_q))
        else $error("interrupt moved disabled stack");

    ctrl_write_a: assert property (@(posedge clk) disable iff (!rst_n)
        wr_ok && acc.sel_ctrl |=>
            auto_page_enable_q == $past(wdata[AUTO_PAGE_ENABLE_BIT]))
        else $error("enable bit write wrong");

    page_read_a: assert property (@(posedge clk) disable iff (!rst_n)
        rd && acc.sel_page |=> rdata_valid
            && rdata == $past(page_select_q))
        else $error("page readback wrong");

    idle_read_a: assert property (@(posedge clk) disable iff (!rst_n)
        !(rd && own_hit) |=> !rdata_valid && rdata == 8'h00)
        else $error("stray read data");

endmodule : sfr_page_stack_control

// ===== sim/core_seq_model.sv
module core_seq_model (
    // Clock
    input  wire logic       clk,
    // Register access
    output logic      [7:0] addr,
    output logic            direct,
    output logic            wr,
    output logic            rd,
    output logic            bit_access,
    output logic      [7:0] wdata,
    input  wire logic [7:0] rdata,
    input  wire logic       rdata_valid,
    // Interrupt events
    output logic            irq_enter,
    output logic            irq_from_bus_unit,
    output logic            irq_return
);
    timeunit 1ns;
    timeprecision 1ps;
    import page_stack_pkg::*;

    initial begin
        addr = 8'h00;
        direct = 1'b0;
        wr = 1'b0;
        rd = 1'b0;
        bit_access = 1'b0;
        wdata = 8'h00;
        irq_enter = 1'b0;
        irq_from_bus_unit = 1'b0;
        irq_return = 1'b0;
    end

    // Released address and data lines show the inverse of their last value; bit_access returns to 0
    task automatic drop();
        addr = ~addr;
        wdata = ~wdata;
        bit_access = 1'b0;
    endtask : drop

    task automatic wr_reg(input logic [7:0] a, d, input logic b);
        @(negedge clk);
        addr = a;
        wdata = d;
        direct = 1'b1;
        bit_access = b;
        wr = 1'b1;
        @(negedge clk);
        wr = 1'b0;
        drop();
    endtask : wr_reg

    task automatic rd_reg(input logic [7:0] a, output logic [7:0] d,
                          output logic v);
        @(negedge clk);
        addr = a;
        direct = 1'b1;
        rd = 1'b1;
        @(negedge clk);
        rd = 1'b0;
        d = rdata;
        v = rdata_valid;
        drop();
    endtask : rd_reg

    task automatic probe(input logic [7:0] a, input logic dm);
        @(negedge clk);
        addr = a;
        direct = dm;
    endtask : probe

    task automatic irq(input logic ent, input logic bus);
        @(negedge clk);
        irq_enter = ent;
        irq_return = !ent;
        irq_from_bus_unit = bus;
        @(negedge clk);
        irq_enter = 1'b0;
        irq_return = 1'b0;
        irq_from_bus_unit = !bus;
    endtask : irq
endmodule : core_seq_model

// ===== sim/sfr_page_stack_control_tb_top.sv
module sfr_page_stack_control_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import page_stack_pkg::*;

    logic        clk, rst_n, direct, wr, rd, bit_access, rdata_valid;
    logic        sfr_space, bit_ok, own_hit, page_known, dm, v;
    logic        irq_enter, irq_from_bus_unit, irq_return;
    logic [7:0]  addr, wdata, rdata, page, a, d, p;
    logic [31:0] seed;
    int          n_fail, checks_done, cyc, pg, nx, ls, en;

    sfr_page_stack_control uut (.clk, .rst_n, .addr, .direct, .wr, .rd,
        .bit_access, .wdata, .rdata, .rdata_valid, .sfr_space, .bit_ok,
        .own_hit, .page, .page_known, .irq_enter, .irq_from_bus_unit,
        .irq_return);
    core_seq_model u_core (.clk, .addr, .direct, .wr, .rd, .bit_access,
        .wdata, .rdata, .rdata_valid, .irq_enter, .irq_from_bus_unit,
        .irq_return);

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    function automatic logic [7:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction : rnd

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic rd_chk(input logic [7:0] ra, exp, input logic ev);
        u_core.rd_reg(ra, d, v);
        chk(8'(v), 8'(ev));
        chk(d, exp);
    endtask : rd_chk

    task automatic stk_chk();
        chk(page, 8'(pg));
        rd_chk(PAGE_SELECT_ADDR, 8'(pg), 1'b1);
        rd_chk(PAGE_STACK_SECOND_ADDR, 8'(nx), 1'b1);
        rd_chk(PAGE_STACK_BOTTOM_ADDR, 8'(ls), 1'b1);
    endtask : stk_chk

    // Reference model of the page stack
    task automatic do_wr(input logic [7:0] wa, wd);
        u_core.wr_reg(wa, wd, 1'b0);
        if (wa == PAGE_SELECT_ADDR) pg = wd;
        else if (wa == PAGE_STACK_SECOND_ADDR) nx = wd;
        else if (wa == PAGE_STACK_BOTTOM_ADDR) ls = wd;
        else if (wa == PAGE_CONTROL_ADDR && pg == PAGE_CONFIG) en = wd[0];
    endtask : do_wr

    task automatic do_irq(input logic ent, input logic bus);
        u_core.irq(ent, bus);
        if (en != 0 && ent) begin
            ls = nx;
            nx = pg;
            pg = bus ? PAGE_BUSCTL : PAGE_MAIN;
        end else if (en != 0) begin
            pg = nx;
            nx = ls;
            ls = 0;
        end
    endtask : do_irq

    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : finish_test

    always @(posedge clk) begin
        cyc++;
        if (cyc == 6000) begin
            n_fail++;
            finish_test();
        end
    end

    initial begin
        rst_n = 1'b0;
        seed = 32'h0000_452b;
        en = 1;
        repeat (5) @(negedge clk);
        rst_n = 1'b1;
        stk_chk();
        do_wr(PAGE_SELECT_ADDR, PAGE_CONFIG);
        rd_chk(PAGE_CONTROL_ADDR, 8'h01, 1'b1);
        do_wr(PAGE_CONTROL_ADDR, 8'hFE);
        rd_chk(PAGE_CONTROL_ADDR, 8'h00, 1'b1);
        do_irq(1'b1, 1'b1);
        stk_chk();
        do_irq(1'b0, 1'b0);
        stk_chk();
        do_wr(PAGE_CONTROL_ADDR, 8'h01);
        do_wr(PAGE_SELECT_ADDR, PAGE_MAIN);
        rd_chk(PAGE_CONTROL_ADDR, 8'h00, 1'b0);
        u_core.wr_reg(PAGE_SELECT_ADDR, 8'h33, 1'b1);
        chk(page, 8'(pg));
        $display("test control done");
        do_irq(1'b1, 1'b1);
        stk_chk();
        do_wr(PAGE_STACK_BOTTOM_ADDR, PAGE_CONFIG);
        stk_chk();
        do_irq(1'b1, 1'b0);
        stk_chk();
        do_irq(1'b0, 1'b0);
        stk_chk();
        do_wr(PAGE_STACK_SECOND_ADDR, PAGE_CONFIG);
        do_irq(1'b0, 1'b0);
        stk_chk();
        $display("test nesting done");
        for (int i = 0; i < 24; i++) begin
            p = (i % 4 == 0) ? PAGE_BUSCTL
                : (i % 4 == 1) ? PAGE_CONFIG : rnd();
            do_wr(PAGE_SELECT_ADDR, p);
            chk(page, p);
            a = rnd();
            if (i % 2 == 0)
                a = a[0] ? (a[1] ? 8'hA7 : 8'hA6) : 8'h84 + 8'(a[1]);
            dm = (i % 3 != 2);
            u_core.probe(a, dm);
            #1;
            chk(8'(sfr_space), 8'(dm && a >= 8'h80));
            chk(8'(bit_ok), 8'(dm && a >= 8'h80 && a[2:0] == 3'h0));
            v = a inside {8'h85, 8'hA6, 8'hA7} || (a == 8'h84 && p == 8'h0F);
            if (dm) chk(8'(own_hit), 8'(v));
            chk(8'(page_known), 8'(p inside {8'h00, 8'h0C, 8'h0F}));
        end
        $display("test decode done");
        for (int i = 0; i < 40; i++) begin
            a = rnd();
            d = rnd();
            case (a % 6)
                0, 1: do_irq(1'b1, d[0]);
                2: do_irq(1'b0, 1'b0);
                3: do_wr(d[0] ? PAGE_STACK_BOTTOM_ADDR : PAGE_CONTROL_ADDR, d);
                4: do_wr(PAGE_STACK_SECOND_ADDR, d);
                default: do_wr(PAGE_SELECT_ADDR, d[1] ? PAGE_CONFIG : d);
            endcase
            stk_chk();
        end
        $display("test random stack done");
        finish_test();
    end
endmodule : sfr_page_stack_control_tb_top
